// >>> rtl/dpio_top.sv
// Purpose: two gpio ports with analog select, axi4-lite slave
// Assumes: single clock aclk, synchronous active-low reset
// Notes: analog input path zeroes digital reads
`timescale 1ns/1ps
`default_nettype none
`include "dpio_cfg.svh"
module dpio_top
    import dpio_pkg::*;
#(
    parameter bit HAS_FIRST_PORT = 1'b1
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [11:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [11:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [7:0] first_port_pins_in,
    output dpio_p1_drive_s first_port_drive,
    input wire logic [3:0] second_port_pins_in,
    output dpio_p2_drive_s second_port_drive,
    input wire logic external_reset_pin_option,
    output logic [7:0] first_port_analog_bit,
    output logic [3:0] cap_sense_channel_select
);
    // ==========================================
    // synchronised pin levels
    logic [7:0] p1_sync;
    logic [3:0] p2_sync;
    logic [0:0] opt_sync;
    dpio_sync #(.W(8)) u_sync_p1 (
        .aclk(aclk),
        .aresetn(aresetn),
        .d(first_port_pins_in),
        .q(p1_sync)
    );
    dpio_sync #(.W(4)) u_sync_p2 (
        .aclk(aclk),
        .aresetn(aresetn),
        .d(second_port_pins_in),
        .q(p2_sync)
    );
    dpio_sync #(.W(1)) u_sync_opt (
        .aclk(aclk),
        .aresetn(aresetn),
        .d(external_reset_pin_option),
        .q(opt_sync)
    );

    // ==========================================
    // registers
    logic [7:0] p1_latch_reg, p1_latch_next;
    logic [7:0] p1_dir_reg, p1_dir_next;
    logic [7:0] p1_ansel_reg, p1_ansel_next;
    logic [3:0] p2_latch_reg, p2_latch_next;
    logic [2:0] p2_dir_reg, p2_dir_next;
    logic [2:0] p2_ansel_reg, p2_ansel_next;
    logic [3:0] cap_ch_reg, cap_ch_next;
    dpio_wstate_e wst_reg, wst_next;
    logic [11:0] awaddr_reg, awaddr_next;
    logic aw_have_reg, aw_have_next;
    logic [31:0] wdata_reg, wdata_next;
    logic w_have_reg, w_have_next;
    logic [1:0] bresp_reg, bresp_next;
    logic rvalid_reg, rvalid_next;
    logic [31:0] rdata_reg, rdata_next;
    logic [1:0] rresp_reg, rresp_next;

    // pin views seen by software
    logic [7:0] p1_view;
    logic [3:0] p2_view;
    logic [7:0] p2_rd8;
    logic [3:0] p2_dir_full;
    logic [3:0] p2_ansel_full;

    // digital read of a pin set: analog pins read zero
    function automatic logic [7:0] digital_read(input logic [7:0] lvl, input logic [7:0] ana);
        digital_read = lvl & ~ana;
    endfunction : digital_read

    // strobe-merged low byte
    function automatic logic [7:0] merge_byte(input logic [7:0] old, input logic [31:0] wd,
                                              input logic [3:0] st);
        merge_byte = st[0] ? wd[7:0] : old;
    endfunction : merge_byte

    // ==========================================
    // pin views and drivers
    always_comb begin
        p2_dir_full = {1'b1, p2_dir_reg};
        p2_ansel_full = {1'b0, p2_ansel_reg};
        p1_view = HAS_FIRST_PORT ? digital_read(p1_sync, p1_ansel_reg) : 8'h00;
        p2_rd8 = digital_read({4'h0, p2_sync}, {4'h0, p2_ansel_full});
        p2_view = p2_rd8[3:0];
        if (opt_sync[0]) begin
            p2_view[`DPIO_P2_TOP_BIT] = 1'b0;
        end
    end

    // output driver: direction zero drives, analog select ignored
    always_comb begin
        first_port_drive.out = p1_latch_reg;
        first_port_drive.oe = HAS_FIRST_PORT ? ~p1_dir_reg : 8'h00;
        second_port_drive.out = p2_latch_reg;
        second_port_drive.oe = ~p2_dir_full;
    end
    assign first_port_analog_bit = HAS_FIRST_PORT ? p1_ansel_reg : 8'h00;
    // channel select names which first port pin senses: n+8
    assign cap_sense_channel_select = cap_ch_reg;

    // ==========================================
    // write channel and register update
    logic wr_fire;
    logic [7:0] wb;
    always_comb begin
        wst_next = wst_reg;
        awaddr_next = awaddr_reg;
        aw_have_next = aw_have_reg;
        wdata_next = wdata_reg;
        w_have_next = w_have_reg;
        bresp_next = bresp_reg;
        p1_latch_next = p1_latch_reg;
        p1_dir_next = p1_dir_reg;
        p1_ansel_next = p1_ansel_reg;
        p2_latch_next = p2_latch_reg;
        p2_dir_next = p2_dir_reg;
        p2_ansel_next = p2_ansel_reg;
        cap_ch_next = cap_ch_reg;
        wr_fire = 1'b0;
        wb = 8'h00;
        s_axi_awready = 1'b0;
        s_axi_wready = 1'b0;
        case (wst_reg)
            DPIO_W_IDLE: begin
                s_axi_awready = !aw_have_reg;
                s_axi_wready = !w_have_reg;
                if (s_axi_awvalid && !aw_have_reg) begin
                    awaddr_next = s_axi_awaddr;
                    aw_have_next = 1'b1;
                end
                if (s_axi_wvalid && !w_have_reg) begin
                    wdata_next = s_axi_wdata;
                    w_have_next = 1'b1;
                end
                if (aw_have_reg && w_have_reg) begin
                    wst_next = DPIO_W_RESP;
                end
            end
            DPIO_W_RESP: begin
                wr_fire = 1'b1;
                bresp_next = `DPIO_RESP_OKAY;
                // merge_byte gets strobe 4'h1: the latch takes the whole low byte of write data, no bit from the pins
                if (awaddr_reg == `DPIO_OFF_P1_DATA) begin
                    wb = merge_byte(p1_view, wdata_reg, 4'h1);
                    if (HAS_FIRST_PORT) begin
                        p1_latch_next = wb;
                    end
                end else if (awaddr_reg == `DPIO_OFF_P1_DIR) begin
                    if (HAS_FIRST_PORT) begin
                        p1_dir_next = wdata_reg[7:0];
                    end
                end else if (awaddr_reg == `DPIO_OFF_P1_ANSEL) begin
                    if (HAS_FIRST_PORT) begin
                        p1_ansel_next = wdata_reg[7:0];
                    end
                end else if (awaddr_reg == `DPIO_OFF_P2_DATA) begin
                    wb = merge_byte({4'h0, p2_view}, wdata_reg, 4'h1);
                    p2_latch_next = wb[3:0];
                end else if (awaddr_reg == `DPIO_OFF_P2_DIR) begin
                    p2_dir_next = wdata_reg[2:0];
                end else if (awaddr_reg == `DPIO_OFF_P2_ANSEL) begin
                    p2_ansel_next = wdata_reg[2:0];
                end else if (awaddr_reg == `DPIO_OFF_CAP_CH) begin
                    cap_ch_next = wdata_reg[3:0];
                end else begin
                    bresp_next = `DPIO_RESP_SLVERR;
                end
                aw_have_next = 1'b0;
                w_have_next = 1'b0;
                wst_next = DPIO_W_HOLD;
            end
            DPIO_W_HOLD: begin
                if (s_axi_bready) begin
                    wst_next = DPIO_W_IDLE;
                end
            end
            default: begin
                wst_next = DPIO_W_IDLE;
            end
        endcase
    end
    assign s_axi_bvalid = (wst_reg == DPIO_W_HOLD);
    assign s_axi_bresp = bresp_reg;

    // ==========================================
    // read channel
    logic [31:0] rd_word;
    logic rd_bad;
    always_comb begin
        rd_word = 32'h0000_0000;
        rd_bad = 1'b0;
        if (s_axi_araddr == `DPIO_OFF_P1_DATA) begin
            rd_word = {24'h00_0000, p1_view};
        end else if (s_axi_araddr == `DPIO_OFF_P1_DIR) begin
            rd_word = {24'h00_0000, HAS_FIRST_PORT ? p1_dir_reg : 8'h00};
        end else if (s_axi_araddr == `DPIO_OFF_P1_ANSEL) begin
            rd_word = {24'h00_0000, first_port_analog_bit};
        end else if (s_axi_araddr == `DPIO_OFF_P2_DATA) begin
            rd_word = {28'h000_0000, p2_view};
        end else if (s_axi_araddr == `DPIO_OFF_P2_DIR) begin
            rd_word = {28'h000_0000, p2_dir_full};
        end else if (s_axi_araddr == `DPIO_OFF_P2_ANSEL) begin
            rd_word = {29'h0000_0000, p2_ansel_reg};
        end else if (s_axi_araddr == `DPIO_OFF_CAP_CH) begin
            rd_word = {28'h000_0000, cap_ch_reg};
        end else begin
            rd_bad = 1'b1;
        end
        s_axi_arready = !rvalid_reg;
        rvalid_next = rvalid_reg;
        rdata_next = rdata_reg;
        rresp_next = rresp_reg;
        if (rvalid_reg && s_axi_rready) begin
            rvalid_next = 1'b0;
        end else if (!rvalid_reg && s_axi_arvalid) begin
            rvalid_next = 1'b1;
            rdata_next = rd_word;
            rresp_next = rd_bad ? `DPIO_RESP_SLVERR : `DPIO_RESP_OKAY;
        end
    end
    assign s_axi_rvalid = rvalid_reg;
    assign s_axi_rdata = rdata_reg;
    assign s_axi_rresp = rresp_reg;

    // ==========================================
    // state registers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wst_reg <= DPIO_W_IDLE;
            awaddr_reg <= 12'h000;
            aw_have_reg <= 1'b0;
            wdata_reg <= 32'h0000_0000;
            w_have_reg <= 1'b0;
            bresp_reg <= 2'b00;
            rvalid_reg <= 1'b0;
            rdata_reg <= 32'h0000_0000;
            rresp_reg <= 2'b00;
            p1_latch_reg <= 8'h00;
            p1_dir_reg <= `DPIO_RST_P1_DIR;
            p1_ansel_reg <= `DPIO_RST_P1_ANSEL;
            p2_latch_reg <= 4'h0;
            p2_dir_reg <= 3'h7;
            p2_ansel_reg <= `DPIO_RST_P2_ANSEL;
            cap_ch_reg <= 4'h0;
        end else begin
            wst_reg <= wst_next;
            awaddr_reg <= awaddr_next;
            aw_have_reg <= aw_have_next;
            wdata_reg <= wdata_next;
            w_have_reg <= w_have_next;
            bresp_reg <= bresp_next;
            rvalid_reg <= rvalid_next;
            rdata_reg <= rdata_next;
            rresp_reg <= rresp_next;
            p1_latch_reg <= p1_latch_next;
            p1_dir_reg <= p1_dir_next;
            p1_ansel_reg <= p1_ansel_next;
            p2_latch_reg <= p2_latch_next;
            p2_dir_reg <= p2_dir_next;
            p2_ansel_reg <= p2_ansel_next;
            cap_ch_reg <= cap_ch_next;
        end
    end

    // ==========================================
    // checks
    a_p1_dir_drive: assert property (@(posedge aclk) disable iff (!aresetn)
        first_port_drive.oe == (HAS_FIRST_PORT ? ~p1_dir_reg : 8'h00))
        else $error("first port enable disagrees with direction");
    a_p2_top_input: assert property (@(posedge aclk) disable iff (!aresetn)
        !second_port_drive.oe[3])
        else $error("input only pin driven");
    a_p2_dir_hiz: assert property (@(posedge aclk) disable iff (!aresetn)
        second_port_drive.oe == ~p2_dir_full)
        else $error("second port enable disagrees with direction");
    a_analog_read_zero: assert property (@(posedge aclk) disable iff (!aresetn)
        (s_axi_arvalid && s_axi_arready && s_axi_araddr == `DPIO_OFF_P1_DATA)
        |=> ((s_axi_rdata[7:0] & $past(p1_ansel_reg)) == 8'h00))
        else $error("analog pin read nonzero");
    a_opt_top_zero: assert property (@(posedge aclk) disable iff (!aresetn)
        (s_axi_arvalid && s_axi_arready && s_axi_araddr == `DPIO_OFF_P2_DATA && opt_sync[0])
        |=> !s_axi_rdata[3])
        else $error("top pin read one under reset option");
    a_dir_read_one: assert property (@(posedge aclk) disable iff (!aresetn)
        (s_axi_arvalid && s_axi_arready && s_axi_araddr == `DPIO_OFF_P2_DIR)
        |=> s_axi_rdata[3])
        else $error("top direction bit read zero");
    a_absent_zero: assert property (@(posedge aclk) disable iff (!aresetn)
        (s_axi_arvalid && s_axi_arready && s_axi_araddr == `DPIO_OFF_P1_ANSEL)
        |=> s_axi_rdata[7:0] == (HAS_FIRST_PORT ? $past(p1_ansel_reg) : 8'h00))
        else $error("absent first port shows state");
    a_sync_delay: assert property (@(posedge aclk) disable iff (!aresetn)
        $past(aresetn, 2) |-> p2_sync == $past(second_port_pins_in, 2))
        else $error("pin sync not two stages");
    a_analog_drives: assert property (@(posedge aclk) disable iff (!aresetn)
        first_port_drive.out == p1_latch_reg)
        else $error("latch not driven");
endmodule : dpio_top
`default_nettype wire

// >>> common/dpio_cfg.svh
// Purpose: constants for the dual port io block
// Assumes: aclk 250 MHz, 32-bit axi4-lite register bus
// Notes: byte offsets are aligned words
// Contract
// - first port direction one means input
// - analog select disables digital input buffer
// - analog pins read data as zero
// - absent first port regs read zero
// - first port pin n is channel n+8
// - second port has four pins, three bidirectional
// - second port direction one means high impedance
// - top second pin input only, direction one
// - second port read pins, write latch
// - data writes are read-modify-write; the code loads the latch from the whole low byte of write data
// - reset pin option forces top pin zero
// - second port direction drives even when analog
// - analog output pin still drives latch
// - first port eight pins, data and direction
`ifndef DPIO_CFG_SVH
`define DPIO_CFG_SVH
// ==========================================
// register byte offsets
`define DPIO_OFF_P1_DATA 12'h000
`define DPIO_OFF_P1_DIR 12'h004
`define DPIO_OFF_P1_ANSEL 12'h008
`define DPIO_OFF_P2_DATA 12'h00C
`define DPIO_OFF_P2_DIR 12'h010
`define DPIO_OFF_P2_ANSEL 12'h014
`define DPIO_OFF_CAP_CH 12'h018
// ==========================================
// reset values and fields
`define DPIO_RST_P1_DIR 8'hFF
`define DPIO_RST_P1_ANSEL 8'hFF
`define DPIO_RST_P2_DIR 4'hF
`define DPIO_RST_P2_ANSEL 3'h7
`define DPIO_CAP_CH_BASE 4'h8
`define DPIO_P2_TOP_BIT 3
`define DPIO_RESP_OKAY 2'b00
`define DPIO_RESP_SLVERR 2'b10
`endif

// >>> common/dpio_pkg.sv
// Purpose: types for the dual port io block
// Assumes: nothing
// Notes: header carries the numbers
package dpio_pkg;
    // ==========================================
    // pin bundles
    typedef struct packed {
        logic [7:0] out;
        logic [7:0] oe;
    } dpio_p1_drive_s;
    typedef struct packed {
        logic [3:0] out;
        logic [3:0] oe;
    } dpio_p2_drive_s;
    typedef enum logic [2:0] {
        DPIO_W_IDLE = 3'b001,
        DPIO_W_RESP = 3'b010,
        DPIO_W_HOLD = 3'b100
    } dpio_wstate_e;
endpackage : dpio_pkg

// >>> rtl/dpio_sync.sv
// Purpose: two-flop synchroniser for pin levels
// Assumes: async inputs
// Notes: first stage read only by second
`timescale 1ns/1ps
`default_nettype none
module dpio_sync #(
    parameter int W = 8
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] s1_reg;
    logic [W-1:0] s2_reg;
    // ==========================================
    // two stages, reset to zero
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s1_reg <= '0;
            s2_reg <= '0;
        end else begin
            s1_reg <= d;
            s2_reg <= s1_reg;
        end
    end
    assign q = s2_reg;
endmodule : dpio_sync
`default_nettype wire

// >>> tb/dpio_pins_model.sv
// Purpose: board side of both ports, the level seen on each pin
// Assumes: bench gives the level that the board puts on undriven pins
// Notes: where both drive, the device wins; contention is not modelled
`timescale 1ns/1ps
`default_nettype none
module dpio_pins_model
    import dpio_pkg::*;
(
    input wire dpio_p1_drive_s p1_drive,
    input wire dpio_p2_drive_s p2_drive,
    input wire logic [7:0] p1_ext,
    input wire logic [3:0] p2_ext,
    output logic [7:0] p1_pins,
    output logic [3:0] p2_pins
);
    // ==========================================
    // pin levels
    // external circuit owns every pin whose driver is off
    assign p1_pins = (p1_drive.out & p1_drive.oe) | (p1_ext & ~p1_drive.oe);
    assign p2_pins = (p2_drive.out & p2_drive.oe) | (p2_ext & ~p2_drive.oe);
endmodule : dpio_pins_model
`default_nettype wire

// >>> tb/testbench.sv
// Purpose: self-checking bench for the dual port io block
// Assumes: first port present, pin model on the far side
// Notes: expected values come from an integer register model
`timescale 1ns/1ps
`default_nettype none
`include "dpio_cfg.svh"
module testbench
    import dpio_pkg::*;
;
    logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready, opt;
    logic [11:0] awaddr, araddr;
    logic [31:0] wdata, rdata;
    logic [3:0] wstrb, p2_ext, p2_pins, cap_sel;
    logic [1:0] bresp, rresp;
    logic [7:0] p1_ext, p1_pins, an_bit;
    dpio_p1_drive_s d1;
    dpio_p2_drive_s d2;
    int n_mismatch, tests_run, m_l1, m_d1, m_a1, m_l2, m_d2, m_a2;

    dpio_top uut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .first_port_pins_in(p1_pins),
        .first_port_drive(d1), .second_port_pins_in(p2_pins), .second_port_drive(d2),
        .external_reset_pin_option(opt), .first_port_analog_bit(an_bit), .cap_sense_channel_select(cap_sel));
    dpio_pins_model board (.p1_drive(d1), .p2_drive(d2), .p1_ext(p1_ext), .p2_ext(p2_ext),
        .p1_pins(p1_pins), .p2_pins(p2_pins));

    // ==========================================
    // clock, 4 ns period
    initial begin
        aclk = 1'b0;
        forever #2 aclk = ~aclk;
    end

    // ==========================================
    // compare and closing tasks
    task automatic chk_val(input string what, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            n_mismatch++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask : chk_val
    task automatic chk_resp(input string what, input logic [1:0] exp, input logic [1:0] got);
        tests_run++;
        if (got !== exp) begin
            n_mismatch++;
            $display("wrong value %s expected %b seen %b", what, exp, got);
        end
    endtask : chk_resp
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : report_and_stop

    // ==========================================
    // bus master: holds each channel until its ready, no assumed latency
    task automatic axi_wr(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
        logic done;
        done = 1'b0;
        r = 2'b11;
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        // only the watchdog ends a wait that never gets its answer
        while (!done) begin
            @(posedge aclk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            if (bvalid) begin
                done = 1'b1;
                r = bresp;
                bready <= 1'b0;
            end
        end
    endtask : axi_wr
    task automatic axi_rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
        logic done;
        done = 1'b0;
        r = 2'b11;
        d = '0;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        while (!done) begin
            @(posedge aclk);
            if (arvalid && arready) arvalid <= 1'b0;
            if (rvalid) begin
                done = 1'b1;
                d = rdata;
                r = rresp;
                rready <= 1'b0;
            end
        end
    endtask : axi_rd
    task automatic wr(input logic [11:0] a, input int v);
        logic [1:0] r;
        axi_wr(a, 32'(v), r);
        chk_resp("write response", `DPIO_RESP_OKAY, r);
    endtask : wr
    task automatic rd_chk(input logic [11:0] a, input int v, input string what);
        logic [1:0] r;
        logic [31:0] d;
        axi_rd(a, d, r);
        chk_val(what, 32'(v), d);
        chk_resp("read response", `DPIO_RESP_OKAY, r);
    endtask : rd_chk

    // ==========================================
    // reference model; pins reach the read path two cycles late, so settle
    function automatic int exp_p1();
        return ((m_l1 & ~m_d1) | (p1_ext & m_d1)) & ~m_a1 & 255;
    endfunction : exp_p1
    function automatic int exp_p2();
        int d, v;
        d = m_d2 | 8;
        v = ((m_l2 & ~d) | (p2_ext & d)) & ~m_a2 & 15;
        return opt ? (v & 7) : v;
    endfunction : exp_p2
    task automatic settle();
        repeat (4) @(posedge aclk);
    endtask : settle
    task automatic check_all(input string name);
        settle();
        chk_val("first drive", 32'({m_l1[7:0], ~m_d1[7:0]}), 32'(d1));
        chk_val("second drive", 32'({m_l2[3:0], ~(m_d2[3:0] | 4'h8)}), 32'(d2));
        chk_val("analog bits", 32'(m_a1), 32'(an_bit));
        rd_chk(`DPIO_OFF_P1_DIR, m_d1, "first dir");
        rd_chk(`DPIO_OFF_P1_ANSEL, m_a1, "first ansel");
        rd_chk(`DPIO_OFF_P1_DATA, exp_p1(), "first data");
        rd_chk(`DPIO_OFF_P2_DIR, m_d2 | 8, "second dir");
        rd_chk(`DPIO_OFF_P2_ANSEL, m_a2, "second ansel");
        rd_chk(`DPIO_OFF_P2_DATA, exp_p2(), "second data");
        $display("test %s done", name);
    endtask : check_all
    task automatic reset_model();
        m_l1 = 0;
        m_d1 = 255;
        m_a1 = 255;
        m_l2 = 0;
        m_d2 = 15;
        m_a2 = 7;
    endtask : reset_model

    // ==========================================
    // watchdog, far above the several hundred cycles the tests need
    initial begin
        repeat (40000) @(posedge aclk);
        n_mismatch++;
        report_and_stop();
    end

    // ==========================================
    // main sequence
    initial begin
        logic [1:0] r;
        logic [31:0] d;
        {awvalid, wvalid, bready, arvalid, rready, opt} = '0;
        awaddr = '0;
        araddr = '0;
        wdata = '0;
        wstrb = 4'hF;
        p1_ext = 8'hA5;
        p2_ext = 4'hF;
        n_mismatch = 0;
        tests_run = 0;
        aresetn = 1'b0;
        void'($urandom(15067));
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        reset_model();
        check_all("reset values");
        // random direction, latch and analog mix, analog pins left driving
        for (int i = 0; i < 8; i++) begin
            m_l1 = $urandom & 255;
            m_d1 = $urandom & 255;
            m_a1 = (i == 7) ? 0 : ($urandom & 255);
            m_l2 = $urandom & 15;
            m_d2 = $urandom & 15;
            m_a2 = (i == 7) ? 0 : ($urandom & 7);
            wr(`DPIO_OFF_P1_DATA, m_l1);
            wr(`DPIO_OFF_P1_DIR, m_d1);
            wr(`DPIO_OFF_P1_ANSEL, m_a1);
            wr(`DPIO_OFF_P2_DATA, m_l2);
            wr(`DPIO_OFF_P2_DIR, m_d2);
            wr(`DPIO_OFF_P2_ANSEL, m_a2);
            p1_ext <= 8'($urandom);
            p2_ext <= 4'($urandom);
            opt <= 1'($urandom);
            check_all("port mix");
        end
        // every sensing channel code
        for (int c = 0; c < 16; c++) begin
            wr(`DPIO_OFF_CAP_CH, c);
            chk_val("cap channel", 32'(c), 32'(cap_sel));
            rd_chk(`DPIO_OFF_CAP_CH, c, "cap channel read");
        end
        $display("test cap channels done");
        // unmapped place: error and no side effect
        axi_wr(12'h01C, 32'h0000_0000, r);
        chk_resp("unmapped write", `DPIO_RESP_SLVERR, r);
        axi_rd(12'h01C, d, r);
        chk_resp("unmapped read", `DPIO_RESP_SLVERR, r);
        check_all("unmapped");
        // second reset in mid-run
        @(posedge aclk);
        aresetn <= 1'b0;
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        reset_model();
        check_all("mid-run reset");
        report_and_stop();
    end
endmodule : testbench
`default_nettype wire
